// file: design/dma_engine_pkg.sv
// Constants, state codes and carrier types for the four-channel DMA engine.
// Assumes one system clock domain; external requests arrive asynchronously.
package dma_engine_pkg;

  localparam int NUM_CHANNELS = 4;
  localparam int EXT_CHANNELS = 2;
  localparam int NUM_SOURCES  = 5;
  localparam int SEL_W        = 3;
  localparam int COUNT_W      = 20;
  localparam int ADDR_W       = 31;
  localparam int DATA_W       = 32;
  localparam int BURST_BEATS  = 4;

  localparam logic [1:0]         HS_RELEASE_CYCLES = 2'h2;
  localparam logic [COUNT_W-1:0] COUNT_RESET       = 20'h00000;
  localparam logic [ADDR_W-1:0]  ADDR_RESET        = 31'h00000000;
  localparam logic [1:0]         BEAT_UNIT_LAST    = 2'h0;
  localparam logic [1:0]         BEAT_BURST_LAST   = 2'h3;

  typedef enum logic [3:0] {
    MAIN_IDLE = 4'h1,
    MAIN_LOAD = 4'h2,
    MAIN_RUN  = 4'h4,
    MAIN_HOLD = 4'h8
  } main_state_type;

  typedef enum logic [3:0] {
    SUB_IDLE  = 4'h1,
    SUB_GRANT = 4'h2,
    SUB_READ  = 4'h4,
    SUB_WRITE = 4'h8
  } sub_state_type;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } data_size_type;

  typedef struct packed {
    logic [ADDR_W-1:0]  src_base;
    logic               src_loc;
    logic               src_fixed;
    logic [ADDR_W-1:0]  dst_base;
    logic               dst_loc;
    logic               dst_fixed;
    logic [COUNT_W-1:0] count;
    logic               int_en;
    logic               whole;
    logic               handshake;
    logic               hw_mode;
    logic [SEL_W-1:0]   src_sel;
    logic               burst4;
    data_size_type      data_size;
  } chan_cfg_type;

  typedef struct packed {
    main_state_type     main;
    logic [COUNT_W-1:0] count;
    logic [ADDR_W-1:0]  cur_src;
    logic [ADDR_W-1:0]  cur_dst;
    logic               ack;
    logic               irq;
    logic               ext_ack_n;
    logic               busy;
    logic               rearm;
    logic [1:0]         hold_cnt;
  } chan_state_type;

  typedef struct packed {
    chan_state_type [NUM_CHANNELS-1:0]  ch;
    logic [EXT_CHANNELS-1:0]            ext_meta_n;
    logic [EXT_CHANNELS-1:0]            ext_sync_n;
    sub_state_type                      sub;
    logic [1:0]                         sel;
    logic [1:0]                         beat;
    logic [BURST_BEATS-1:0][DATA_W-1:0] data_buf;
    logic                               bus_req;
    logic                               bus_rd;
    logic                               bus_wr;
    logic                               bus_loc;
    data_size_type                      bus_size;
    logic [ADDR_W-1:0]                  bus_addr;
    logic [DATA_W-1:0]                  bus_wdata;
  } engine_state_type;

endpackage

// file: design/dma_engine.sv
// Four-channel DMA engine: per-channel main machines sharing one
// read-then-write sub-machine that masters the bus.
// Assumes an external arbiter answering bus_req with bus_grant, and a bus
// that completes each read or write in the cycle bus_ready is high.
`timescale 1ns/100ps
module dma_engine
  import dma_engine_pkg::*;
(
  input  wire logic                                   mclk,
  input  wire logic                                   rst_n,
  input  wire logic                                   ce,
  input  wire chan_cfg_type [NUM_CHANNELS-1:0]        cfg,
  input  wire logic [NUM_CHANNELS-1:0]                sw_trigger,
  input  wire logic [NUM_CHANNELS-1:0][NUM_SOURCES-1:0] periph_request,
  input  wire logic [EXT_CHANNELS-1:0]                ext_request_n,
  input  wire logic                                   bus_grant,
  input  wire logic                                   bus_ready,
  input  wire logic [DATA_W-1:0]                      bus_rdata,
  output      logic [EXT_CHANNELS-1:0]                ext_acknowledge_n,
  output      logic [NUM_CHANNELS-1:0]                ch_ack,
  output      logic [NUM_CHANNELS-1:0]                ch_irq,
  output      logic [NUM_CHANNELS-1:0][COUNT_W-1:0]   remaining_transfer_count,
  output      logic                                   bus_req,
  output      logic                                   bus_rd,
  output      logic                                   bus_wr,
  output      logic                                   bus_loc,
  output      data_size_type                          bus_size,
  output      logic [ADDR_W-1:0]                      bus_addr,
  output      logic [DATA_W-1:0]                      bus_wdata
);

  engine_state_type state_q;
  engine_state_type state_d;

  // Request level seen by one channel
  function automatic logic pick_request(
    input int unsigned                  chan,
    input chan_cfg_type                 c,
    input logic                         sw,
    input logic [EXT_CHANNELS-1:0]      sync_n,
    input logic [NUM_SOURCES-1:0]       periph
  );
    logic r;
    r = 1'b0;
    if (!c.hw_mode) begin
      r = sw;
    end else if (c.src_sel == 3'h0 && chan < EXT_CHANNELS) begin
      r = ~sync_n[chan[0]];
    end else if (c.src_sel < SEL_W'(NUM_SOURCES)) begin
      r = periph[c.src_sel];
    end
    return r;
  endfunction

  function automatic logic uses_ext(input int unsigned chan, input chan_cfg_type c);
    return c.hw_mode && c.src_sel == 3'h0 && chan < EXT_CHANNELS;
  endfunction

  // Address of a beat, or of the next chunk when n is the beat count
  function automatic logic [ADDR_W-1:0] step_addr(
    input logic [ADDR_W-1:0] base,
    input logic [2:0]        n,
    input data_size_type     size
  );
    return base + (ADDR_W'(n) << size);
  endfunction

  always_comb begin
    logic [NUM_CHANNELS-1:0] want;
    logic [NUM_CHANNELS-1:0] req_now;
    logic                    found;
    logic                    done;
    logic                    zero;
    logic [1:0]              last;
    chan_cfg_type            c;
    chan_state_type          s;
    want    = '0;
    req_now = '0;
    found   = 1'b0;
    done    = 1'b0;
    zero    = 1'b0;
    last    = BEAT_UNIT_LAST;
    c       = '0;
    s       = '0;
    state_d = state_q;

    // Two stages on mclk; the first stage feeds only the second
    state_d.ext_meta_n = ext_request_n;
    state_d.ext_sync_n = state_q.ext_meta_n;

    for (int unsigned i = 0; i < NUM_CHANNELS; i++) begin
      c          = cfg[i];
      s          = state_q.ch[i];
      req_now[i] = pick_request(i, c, sw_trigger[i], state_q.ext_sync_n, periph_request[i]);
      if (s.main == MAIN_RUN && !s.busy && s.count != COUNT_RESET) begin
        if (!c.whole) begin
          want[i] = 1'b1;
        end else begin
          want[i] = !c.hw_mode || (req_now[i] && !s.rearm);
        end
      end
    end

    // Shared read-then-write sub-machine
    c    = cfg[state_q.sel];
    s    = state_q.ch[state_q.sel];
    last = c.burst4 ? BEAT_BURST_LAST : BEAT_UNIT_LAST;
    case (state_q.sub)
      SUB_IDLE: begin
        for (int unsigned i = 0; i < NUM_CHANNELS; i++) begin
          if (want[i] && !found) begin
            found               = 1'b1;
            state_d.sel         = i[1:0];
            state_d.ch[i].busy  = 1'b1;
            state_d.sub         = SUB_GRANT;
            state_d.bus_req     = 1'b1;
          end
        end
      end
      SUB_GRANT: begin
        if (bus_grant) begin
          state_d.sub      = SUB_READ;
          state_d.beat     = 2'h0;
          state_d.bus_rd   = 1'b1;
          state_d.bus_loc  = c.src_loc;
          state_d.bus_size = c.data_size;
          state_d.bus_addr = s.cur_src;
        end
      end
      SUB_READ: begin
        if (bus_ready) begin
          state_d.data_buf[state_q.beat] = bus_rdata;
          if (state_q.beat == last) begin
            state_d.sub       = SUB_WRITE;
            state_d.beat      = 2'h0;
            state_d.bus_rd    = 1'b0;
            state_d.bus_wr    = 1'b1;
            state_d.bus_loc   = c.dst_loc;
            state_d.bus_addr  = s.cur_dst;
            state_d.bus_wdata = (last == BEAT_UNIT_LAST) ? bus_rdata : state_q.data_buf[0];
          end else begin
            state_d.beat     = state_q.beat + 2'h1;
            state_d.bus_addr = step_addr(s.cur_src, {1'b0, state_q.beat + 2'h1}, c.data_size);
          end
        end
      end
      SUB_WRITE: begin
        if (bus_ready) begin
          if (state_q.beat == last) begin
            state_d.sub     = SUB_IDLE;
            state_d.bus_wr  = 1'b0;
            state_d.bus_req = 1'b0;
            done            = 1'b1;
          end else begin
            state_d.beat      = state_q.beat + 2'h1;
            state_d.bus_addr  = step_addr(s.cur_dst, {1'b0, state_q.beat + 2'h1}, c.data_size);
            state_d.bus_wdata = state_q.data_buf[state_q.beat + 2'h1];
          end
        end
      end
      default: begin
        state_d.sub     = SUB_IDLE;
        state_d.bus_req = 1'b0;
        state_d.bus_rd  = 1'b0;
        state_d.bus_wr  = 1'b0;
      end
    endcase

    // Per-channel main machines
    for (int unsigned i = 0; i < NUM_CHANNELS; i++) begin
      c                 = cfg[i];
      s                 = state_q.ch[i];
      zero              = 1'b0;
      state_d.ch[i].irq = 1'b0;
      case (s.main)
        MAIN_IDLE: begin
          state_d.ch[i].ack       = 1'b0;
          state_d.ch[i].ext_ack_n = 1'b1;
          if (req_now[i]) begin
            state_d.ch[i].main = MAIN_LOAD;
          end
        end
        MAIN_LOAD: begin
          state_d.ch[i].ack       = 1'b1;
          state_d.ch[i].ext_ack_n = !uses_ext(i, c);
          state_d.ch[i].rearm     = 1'b0;
          state_d.ch[i].hold_cnt  = 2'h0;
          state_d.ch[i].main      = MAIN_RUN;
          // Reload only at a run start, so single service counts down
          if (s.count == COUNT_RESET) begin
            state_d.ch[i].count   = c.count;
            state_d.ch[i].cur_src = c.src_base;
            state_d.ch[i].cur_dst = c.dst_base;
          end
        end
        MAIN_RUN: begin
          if (s.rearm && !req_now[i]) begin
            state_d.ch[i].rearm = 1'b0;
          end
          if (done && state_q.sel == i[1:0]) begin
            state_d.ch[i].busy  = 1'b0;
            state_d.ch[i].count = s.count - 20'h00001;
            zero                = (s.count == 20'h00001);
            if (!c.src_fixed) begin
              state_d.ch[i].cur_src = step_addr(s.cur_src, {1'b0, last} + 3'h1, c.data_size);
            end
            if (!c.dst_fixed) begin
              state_d.ch[i].cur_dst = step_addr(s.cur_dst, {1'b0, last} + 3'h1, c.data_size);
            end
            state_d.ch[i].irq   = zero && c.int_en;
            // Handshake needs a release before the next transfer
            state_d.ch[i].rearm = c.hw_mode && c.handshake && req_now[i];
            if (zero || !c.whole) begin
              if (c.hw_mode && c.handshake) begin
                state_d.ch[i].main     = MAIN_HOLD;
                state_d.ch[i].hold_cnt = 2'h0;
              end else begin
                state_d.ch[i].ack       = 1'b0;
                state_d.ch[i].ext_ack_n = 1'b1;
                state_d.ch[i].main      = MAIN_IDLE;
              end
            end
          end else if (!s.busy && s.count == COUNT_RESET) begin
            // Loaded with zero: nothing to move, close the run
            state_d.ch[i].ack       = 1'b0;
            state_d.ch[i].ext_ack_n = 1'b1;
            state_d.ch[i].main      = MAIN_IDLE;
          end
        end
        MAIN_HOLD: begin
          if (req_now[i]) begin
            state_d.ch[i].hold_cnt = 2'h0;
          end else if (s.hold_cnt == HS_RELEASE_CYCLES - 2'h1) begin
            state_d.ch[i].ack       = 1'b0;
            state_d.ch[i].ext_ack_n = 1'b1;
            state_d.ch[i].main      = MAIN_IDLE;
          end else begin
            state_d.ch[i].hold_cnt = s.hold_cnt + 2'h1;
          end
        end
        default: begin
          state_d.ch[i].main = MAIN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q            <= '0;
      state_q.ext_meta_n <= '1;
      state_q.ext_sync_n <= '1;
      state_q.sub        <= SUB_IDLE;
      state_q.bus_size   <= SIZE_BYTE;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        state_q.ch[i].main      <= MAIN_IDLE;
        state_q.ch[i].count     <= COUNT_RESET;
        state_q.ch[i].cur_src   <= ADDR_RESET;
        state_q.ch[i].cur_dst   <= ADDR_RESET;
        state_q.ch[i].ext_ack_n <= 1'b1;
      end
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      ch_ack[i]                   = state_q.ch[i].ack;
      ch_irq[i]                   = state_q.ch[i].irq;
      remaining_transfer_count[i] = state_q.ch[i].count;
    end
    for (int i = 0; i < EXT_CHANNELS; i++) begin
      ext_acknowledge_n[i] = state_q.ch[i].ext_ack_n;
    end
  end

  assign bus_req   = state_q.bus_req;
  assign bus_rd    = state_q.bus_rd;
  assign bus_wr    = state_q.bus_wr;
  assign bus_loc   = state_q.bus_loc;
  assign bus_size  = state_q.bus_size;
  assign bus_addr  = state_q.bus_addr;
  assign bus_wdata = state_q.bus_wdata;

endmodule

// file: verification/dma_engine_monitor.sv
// Concurrent checks on the DMA engine ports, bound into every dma_engine.
// Assumes the single mclk domain and the active-low asynchronous reset.
`timescale 1ns/100ps
module dma_engine_monitor
  import dma_engine_pkg::*;
(
  input wire logic                                 mclk,
  input wire logic                                 rst_n,
  input wire chan_cfg_type [NUM_CHANNELS-1:0]      cfg,
  input wire logic [EXT_CHANNELS-1:0]              ext_request_n,
  input wire logic [EXT_CHANNELS-1:0]              ext_acknowledge_n,
  input wire logic [NUM_CHANNELS-1:0]              ch_ack,
  input wire logic [NUM_CHANNELS-1:0]              ch_irq,
  input wire logic [NUM_CHANNELS-1:0][COUNT_W-1:0] remaining_transfer_count,
  input wire logic                                 bus_req,
  input wire logic                                 bus_rd,
  input wire logic                                 bus_wr,
  input wire logic                                 bus_grant,
  input wire logic                                 bus_ready,
  input wire logic [ADDR_W-1:0]                    bus_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_tenure_end;
    bus_req ##1 !bus_req;
  endsequence

  sequence s_cmd_wait;
    (bus_rd || bus_wr) && !bus_ready;
  endsequence

  a_cmd_exclusive: assert property (!(bus_rd && bus_wr))
    else $error("read and write commands overlap");
  a_cmd_held: assert property (s_cmd_wait |=> $stable(bus_addr) && $stable({bus_rd, bus_wr}))
    else $error("command changed before ready");
  a_tenure_span: assert property (s_tenure_end |-> $past(bus_wr && bus_ready))
    else $error("bus request dropped inside a chunk");
  a_cmd_in_tenure: assert property ((bus_rd || bus_wr) |-> bus_req)
    else $error("command without bus request");
  a_rd_after_grant: assert property ($rose(bus_rd) |-> $past(bus_grant))
    else $error("read started without grant");
  a_bus_needs_ack: assert property ($rose(bus_req) |-> (|ch_ack))
    else $error("bus requested with no channel acknowledged");

  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
    a_irq_at_zero: assert property (
      ch_irq[i] |-> remaining_transfer_count[i] == '0 && cfg[i].int_en)
      else $error("interrupt without zero count and enable");
    a_irq_one_cycle: assert property (ch_irq[i] |=> !ch_irq[i])
      else $error("interrupt pulse longer than one cycle");
  end

  for (genvar e = 0; e < EXT_CHANNELS; e++) begin : g_pin
    a_sync_delay: assert property (
      $fell(ext_acknowledge_n[e]) |->
        $past(!ext_request_n[e], 2) && $past(!ext_request_n[e], 3))
      else $error("pin acknowledge ahead of synchroniser");
    a_hs_release: assert property (
      $rose(ext_acknowledge_n[e]) && cfg[e].handshake |->
        $past(ext_request_n[e], 1) && $past(ext_request_n[e], 2))
      else $error("handshake acknowledge dropped early");
    a_hs_hold: assert property (
      cfg[e].handshake && !ext_acknowledge_n[e] && !ext_request_n[e] |=> !ext_acknowledge_n[e])
      else $error("handshake acknowledge released under request");
  end
endmodule

bind dma_engine dma_engine_monitor mon_u (.mclk, .rst_n, .cfg, .ext_request_n, .ext_acknowledge_n,
  .ch_ack, .ch_irq, .remaining_transfer_count, .bus_req, .bus_rd, .bus_wr, .bus_grant,
  .bus_ready, .bus_addr);

// file: verification/far_side_model.sv
// Far side of the engine: bus arbiter and memory, plus the two pin requesters.
// Assumes go levels from the bench; read data is derived from the address.
`timescale 1ns/100ps
module far_side_model
  import dma_engine_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    slow,
  input  wire logic [EXT_CHANNELS-1:0] go,
  input  wire logic                    bus_req,
  input  wire logic                    bus_rd,
  input  wire logic                    bus_wr,
  input  wire logic [ADDR_W-1:0]       bus_addr,
  input  wire logic [EXT_CHANNELS-1:0] ext_acknowledge_n,
  output      logic                    bus_grant,
  output      logic                    bus_ready,
  output      logic [DATA_W-1:0]       bus_rdata,
  output      logic [EXT_CHANNELS-1:0] ext_request_n
);
  logic [1:0] wait_q;

  // Slow mode stretches every beat by two wait cycles
  assign bus_ready = (bus_rd || bus_wr) && (wait_q == (slow ? 2'h2 : 2'h0));
  // Outside a read beat the lines carry the inverse, so stale data never matches
  assign bus_rdata = (bus_rd && bus_ready) ? {1'b1, bus_addr} : ~{1'b1, bus_addr};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q        <= 2'h0;
      bus_grant     <= 1'b0;
      ext_request_n <= 2'h3;
    end else begin
      bus_grant <= bus_req;
      wait_q    <= (bus_ready || !(bus_rd || bus_wr)) ? 2'h0 : wait_q + 2'h1;
      for (int e = 0; e < EXT_CHANNELS; e++) begin
        if (!go[e]) ext_request_n[e] <= 1'b1;
        else if (ext_acknowledge_n[e]) ext_request_n[e] <= 1'b0;
      end
    end
  end
endmodule

// file: verification/dma_engine_tb.sv
// Self-checking bench for the DMA engine: software, peripheral and pin starts.
// Assumes the far-side model answers the bus and drives the request pins.
`timescale 1ns/100ps
module dma_engine_tb;
  import dma_engine_pkg::*;
  logic                                     mclk, rst_n, ce, slow, bus_grant, bus_ready;
  logic                                     bus_req, bus_rd, bus_wr, bus_loc;
  chan_cfg_type [NUM_CHANNELS-1:0]          cfg;
  logic [NUM_CHANNELS-1:0]                  sw_trigger, ch_ack, ch_irq;
  logic [NUM_CHANNELS-1:0][NUM_SOURCES-1:0] periph_request;
  logic [NUM_CHANNELS-1:0][COUNT_W-1:0]     remaining_transfer_count;
  logic [EXT_CHANNELS-1:0]                  ext_request_n, ext_acknowledge_n, go;
  logic [DATA_W-1:0]                        bus_rdata, bus_wdata;
  logic [ADDR_W-1:0]                        bus_addr;
  data_size_type                            bus_size;
  logic [31:0]                              ra[$], wa[$], wd[$];
  data_size_type                            ws[$];
  int                                       irqs[NUM_CHANNELS];
  int                                       error_cnt = 0;
  int                                       compares = 0;
  int                                       k;

  dma_engine dut_u (.mclk, .rst_n, .ce, .cfg, .sw_trigger, .periph_request, .ext_request_n,
    .bus_grant, .bus_ready, .bus_rdata, .ext_acknowledge_n, .ch_ack, .ch_irq,
    .remaining_transfer_count, .bus_req, .bus_rd, .bus_wr, .bus_loc, .bus_size, .bus_addr,
    .bus_wdata);
  far_side_model far_u (.mclk, .rst_n, .slow, .go, .bus_req, .bus_rd, .bus_wr, .bus_addr,
    .ext_acknowledge_n, .bus_grant, .bus_ready, .bus_rdata, .ext_request_n);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Log keeps the bus location in bit 31, so location and address compare together
  always @(posedge mclk) begin
    if (bus_ready === 1'b1 && bus_rd === 1'b1) ra.push_back({bus_loc, bus_addr});
    if (bus_ready === 1'b1 && bus_wr === 1'b1) begin
      wa.push_back({bus_loc, bus_addr});
      wd.push_back(bus_wdata);
      ws.push_back(bus_size);
    end
    for (int i = 0; i < NUM_CHANNELS; i++) if (ch_irq[i] === 1'b1) irqs[i]++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for n logged writes and a quiet engine
  task automatic settle(input int n);
    int t;
    for (t = 0; t < 2000 && !(wa.size() >= n && bus_req === 1'b0 && ch_ack === 4'h0); t++)
      @(negedge mclk);
    if (t == 2000) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (4) @(negedge mclk);
  endtask

  task automatic fresh();
    ra.delete();
    wa.delete();
    wd.delete();
    ws.delete();
    foreach (irqs[i]) irqs[i] = 0;
  endtask

  // f = src_loc, src_fixed, dst_loc, dst_fixed, int_en, whole, handshake, hw_mode, burst4
  task automatic cfg_set(input int ch, input logic [30:0] s, input logic [30:0] d,
                         input logic [19:0] n, input logic [8:0] f, input data_size_type z,
                         input logic [2:0] sel);
    cfg[ch] = '{s, f[8], f[7], d, f[6], f[5], n, f[4], f[3], f[2], f[1], sel, f[0], z};
  endtask

  task automatic pulse_sw(input int ch);
    sw_trigger[ch] = 1'b1;
    @(negedge mclk);
    sw_trigger[ch] = 1'b0;
  endtask

  initial begin
    {rst_n, slow, sw_trigger, periph_request, go, cfg} = '0;
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    fresh();
    cfg_set(1, 31'h100, 31'h200, 20'h2, 9'h110, SIZE_WORD, 3'h0);
    pulse_sw(1);
    settle(1);
    check("read address", ra[0], {1'b1, 31'h100});
    check("write address", wa[0], {1'b0, 31'h200});
    check("write data", wd[0], {1'b1, 31'h100});
    check("count after one", remaining_transfer_count[1], 32'h1);
    check("early irq", irqs[1], 32'h0);
    // Frozen engine must not take the trigger
    ce = 1'b0;
    pulse_sw(1);
    repeat (4) @(negedge mclk);
    check("frozen ack", ch_ack[1], 32'h0);
    check("frozen writes", wa.size(), 32'h1);
    ce = 1'b1;
    pulse_sw(1);
    settle(2);
    check("second address", wa[1], {1'b0, 31'h204});
    check("count at zero", remaining_transfer_count[1], 32'h0);
    check("irq at zero", irqs[1], 32'h1);
    check("writes per request", wa.size(), 32'h2);
    $display("test software single done");
    slow = 1'b1;
    fresh();
    cfg_set(3, 31'h400, 31'h800, 20'h2, 9'h0c9, SIZE_HALF, 3'h0);
    pulse_sw(3);
    settle(8);
    for (k = 0; k < 8; k++) begin
      check("burst read", ra[k], {1'b0, 31'h400 + 31'(2 * (k % 4))});
      check("burst write", wa[k], {1'b1, 31'h800 + 31'(2 * k)});
    end
    check("whole writes", wa.size(), 32'h8);
    check("burst size", ws[0], SIZE_HALF);
    check("masked irq", irqs[3], 32'h0);
    slow = 1'b0;
    $display("test whole burst done");
    fresh();
    cfg_set(2, 31'h10, 31'h20, 20'h1, 9'h012, SIZE_WORD, 3'h2);
    periph_request[2] = 5'h02;
    repeat (10) @(negedge mclk);
    check("unselected source", wa.size(), 32'h0);
    periph_request[2] = 5'h04;
    @(negedge mclk);
    periph_request[2] = 5'h00;
    settle(1);
    check("peripheral write", wa[0], {1'b0, 31'h20});
    check("peripheral irq", irqs[2], 32'h1);
    $display("test peripheral done");
    fresh();
    cfg_set(0, 31'h30, 31'h40, 20'h2, 9'h012, SIZE_BYTE, 3'h0);
    go[0] = 1'b1;
    // Release after the first write; the second run comes from the still-low pin
    for (k = 0; k < 400 && wa.size() < 1; k++) @(negedge mclk);
    if (k == 400) begin
      error_cnt++;
      report_and_stop();
    end
    go[0] = 1'b0;
    settle(2);
    check("demand second", wa[1], {1'b0, 31'h41});
    check("demand writes", wa.size(), 32'h2);
    check("demand irq", irqs[0], 32'h1);
    check("pin ack idle", ext_acknowledge_n[0], 32'h1);
    $display("test pin demand done");
    fresh();
    cfg_set(1, 31'h50, 31'h60, 20'h1, 9'h006, SIZE_WORD, 3'h0);
    go[1] = 1'b1;
    for (k = 0; k < 100 && ext_acknowledge_n[1] !== 1'b0; k++) @(negedge mclk);
    if (k == 100) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (30) @(negedge mclk);
    check("ack held", ext_acknowledge_n[1], 32'h0);
    check("channel ack held", ch_ack[1], 32'h1);
    check("handshake write", wa[0], {1'b0, 31'h60});
    go[1] = 1'b0;
    settle(1);
    check("ack released", ext_acknowledge_n[1], 32'h1);
    $display("test pin handshake done");
    report_and_stop();
  end
endmodule
